// ---- src/region_protection_unit.sv ----
// region_protection_unit: checks core accesses against numbered protection regions
module region_protection_unit
   import rpu_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // unit configuration
   input wire logic unit_on_i,
   input wire logic privileged_background_map_i,
   input wire logic check_in_fault_handlers_i,
   // region configuration port
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [RGN_IDX_W-1:0] region_number_i,
   input wire logic [ADDR_W-1:0] region_base_i,
   input wire region_attributes_s region_attributes_i,
   output region_entry_s cfg_rd_data_o,
   output logic cfg_rd_valid_o,
   // access check port
   input wire logic acc_valid_i,
   input wire access_req_s acc_req_i,
   output logic acc_done_o,
   output logic acc_fault_o
);

   // ************************************************************
   // region table
   // ************************************************************
   region_entry_s table_w [N_REGIONS];  // live settings of every region
   region_entry_s wr_entry_w;           // entry being written

   assign wr_entry_w = '{region_base: region_base_i, region_attributes: region_attributes_i};

   // region number steers which entry is written or read back
   region_store u_store (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .wr_i(cfg_wr_i),
      .rd_i(cfg_rd_i),
      .idx_i(region_number_i),
      .wr_data_i(wr_entry_w),
      .rd_data_o(cfg_rd_data_o),
      .rd_valid_o(cfg_rd_valid_o),
      .table_o(table_w)
   );

   // ************************************************************
   // per-region match
   // ************************************************************
   logic [N_REGIONS-1:0] hit_w;  // region enabled and address inside it

   // only high bits above the size are compared, so a misaligned base just
   // behaves as its aligned-down value; the masked sub-region is a hole
   for (genvar g = 0; g < N_REGIONS; g++) begin : g_hit
      assign hit_w[g] = table_w[g].region_attributes.region_on
                        && region_match(acc_req_i.addr, table_w[g]);

      // a size code past the largest is stored but must never match
      chk_bad_size_idle: assert property (
         @(posedge ref_clk_i) disable iff (!reset_n_i)
         table_w[g].region_attributes.size_code > SIZE_CODE_MAX |-> !hit_w[g])
         else $error("region with unused size code matches");

      // a switched-off region keeps its settings but stays out of every decision
      chk_off_never_hits: assert property (
         @(posedge ref_clk_i) disable iff (!reset_n_i)
         !table_w[g].region_attributes.region_on |-> !hit_w[g])
         else $error("switched-off region matches");
   end

   // ************************************************************
   // priority select
   // ************************************************************
   logic [RGN_IDX_W-1:0] win_idx_w;  // highest-numbered hitting region
   logic any_hit_w;                  // at least one region hit

   // later regions overwrite earlier ones, so the top number wins
   always_comb begin
      win_idx_w = '0;
      for (int i = 0; i < N_REGIONS; i++) begin
         if (hit_w[i]) begin
            win_idx_w = RGN_IDX_W'(i);
         end
      end
   end

   assign any_hit_w = |hit_w;

   // ************************************************************
   // permission decode
   // ************************************************************
   region_attributes_s win_attr_w;  // attributes of the winning region
   logic checking_w;                // checking is in force for this access
   logic rw_ok_w;                   // read/write right held
   logic exec_ok_w;                 // fetch allowed
   logic region_ok_w;               // winning region allows the access
   logic miss_ok_w;                 // miss served by the background map
   logic fault_nxt;                 // next value of the fault flag

   assign win_attr_w = table_w[win_idx_w].region_attributes;

   // handlers run unchecked unless the option keeps checking alive there
   assign checking_w = unit_on_i
                       && (!acc_req_i.in_handler || check_in_fault_handlers_i);

   // rights by privilege; fetches need read right too
   assign rw_ok_w = acc_req_i.write ? may_write(win_attr_w.access, acc_req_i.priv)
                                    : may_read(win_attr_w.access, acc_req_i.priv);
   assign exec_ok_w = !acc_req_i.fetch || (win_attr_w.exec_off == EXECUTE_ALLOWED);
   assign region_ok_w = rw_ok_w && exec_ok_w;

   // a miss is only rescued for privileged code with the option set
   assign miss_ok_w = acc_req_i.priv && privileged_background_map_i;

   assign fault_nxt = acc_valid_i && checking_w
                      && (any_hit_w ? !region_ok_w : !miss_ok_w);

   // ************************************************************
   // result register
   // ************************************************************
   // answer one cycle after the request; fault is a one-cycle pulse
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         acc_done_o <= 1'b0;
         acc_fault_o <= 1'b0;
      end else begin
         acc_done_o <= acc_valid_i;
         acc_fault_o <= fault_nxt;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   chk_off_no_fault: assert property (
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      !unit_on_i |=> !acc_fault_o)
      else $error("fault raised while unit off");

   chk_done_follows: assert property (
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      acc_valid_i |=> acc_done_o ##1 (acc_done_o == $past(acc_valid_i)))
      else $error("answer not one cycle after request");

   chk_fault_has_done: assert property (
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      acc_fault_o |-> acc_done_o && $past(acc_valid_i && unit_on_i))
      else $error("fault without a checked request");

   chk_fetch_forbid: assert property (
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      acc_valid_i && checking_w && any_hit_w && acc_req_i.fetch
      && win_attr_w.exec_off |=> acc_fault_o)
      else $error("fetch from forbidden region not faulted");

   chk_user_miss: assert property (
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      acc_valid_i && checking_w && !any_hit_w && !acc_req_i.priv |=> acc_fault_o)
      else $error("user miss not faulted");

   chk_priv_bg_map: assert property (
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      acc_valid_i && !any_hit_w && acc_req_i.priv && privileged_background_map_i
      |=> !acc_fault_o)
      else $error("privileged miss faulted despite background map");

   chk_handler_free: assert property (
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      acc_valid_i && acc_req_i.in_handler && !check_in_fault_handlers_i |=> !acc_fault_o)
      else $error("fault inside handler while checking suspended");

   chk_winner_top: assert property (
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      any_hit_w |-> hit_w[win_idx_w] && ((hit_w >> win_idx_w) == N_REGIONS'(1)))
      else $error("winning region is not the highest hit");

   chk_off_region_idle: assert property (
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      cfg_wr_i && !region_attributes_i.region_on
      |=> !hit_w[$past(region_number_i)])
      else $error("disabled region still matches");

   chk_readback: assert property (
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      cfg_rd_i |=> cfg_rd_valid_o && cfg_rd_data_o == $past(table_w[region_number_i]))
      else $error("read back does not show selected region");

   // read valid is only ever the echo of a read strobe
   chk_rd_valid_pulse: assert property (
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      !cfg_rd_i |=> !cfg_rd_valid_o)
      else $error("read valid without a read strobe");

   // no request, no answer and no fault
   chk_idle_quiet: assert property (
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      !acc_valid_i |=> !acc_done_o && !acc_fault_o)
      else $error("answer or fault without a request");

   // privileged miss without the background map is a violation
   chk_priv_miss_fault: assert property (
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      acc_valid_i && checking_w && !any_hit_w && acc_req_i.priv
      && !privileged_background_map_i |=> acc_fault_o)
      else $error("privileged miss not faulted without background map");

   chk_user_write: assert property (
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      acc_valid_i && checking_w && any_hit_w && !acc_req_i.priv && acc_req_i.write
      && win_attr_w.access != ACCESS_PRIVRW_USERRW |=> acc_fault_o)
      else $error("user write allowed without user write right");

endmodule : region_protection_unit

// ---- src/region_store.sv ----
// region_store: table of region settings with a registered read port
module region_store
   import rpu_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic wr_i,                        // write strobe
   input wire logic rd_i,                        // read strobe
   input wire logic [RGN_IDX_W-1:0] idx_i,       // region number
   input wire region_entry_s wr_data_i,          // base and attributes to store
   output region_entry_s rd_data_o,              // registered read data
   output logic rd_valid_o,                      // read data valid pulse
   output region_entry_s table_o [N_REGIONS]     // whole table for the checker
);

   // ************************************************************
   // storage
   // ************************************************************
   region_entry_s mem_r [N_REGIONS];  // regions start off after reset

   // one entry per region, written only when its number is selected
   for (genvar g = 0; g < N_REGIONS; g++) begin : g_entry
      always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            mem_r[g] <= ENTRY_RESET;
         end else if (wr_i && idx_i == RGN_IDX_W'(g)) begin
            mem_r[g] <= wr_data_i;
         end
      end
      assign table_o[g] = mem_r[g];
   end

   // ************************************************************
   // read port
   // ************************************************************
   // read data out of a register, enable state included
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_data_o <= ENTRY_RESET;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= rd_i;
         if (rd_i) begin
            rd_data_o <= mem_r[idx_i];
         end
      end
   end

endmodule : region_store

// ---- src/rpu_pkg.sv ----
// rpu_pkg: shared constants, types and decode functions of the region protection unit
package rpu_pkg;

   // ************************************************************
   // sizes and field layout
   // ************************************************************
   localparam int N_REGIONS = 8;                  // number of protection regions
   localparam int RGN_IDX_W = 3;                  // width of a region number
   localparam int ADDR_W = 32;                    // access and base address width
   localparam logic [5:0] SIZE_LOG2_MIN = 6'h05;  // smallest region is 2^5 = 32 bytes
   localparam logic [4:0] SIZE_CODE_MAX = 5'h1b;  // code 27 selects 4 gigabytes
   localparam logic [4:0] SUB_MIN_CODE = 5'h03;   // code 3 is 256 bytes, first with sub-regions
   localparam logic [5:0] SUB_SHIFT = 6'h03;      // eight sub-regions, three index bits

   // read/write access settings
   localparam logic [2:0] ACCESS_NONE_NONE = 3'h0;
   localparam logic [2:0] ACCESS_PRIVRW_USERNONE = 3'h1;
   localparam logic [2:0] ACCESS_PRIVRW_USERRO = 3'h2;
   localparam logic [2:0] ACCESS_PRIVRW_USERRW = 3'h3;
   localparam logic [2:0] ACCESS_PRIVRO_USERNONE = 3'h4;
   localparam logic [2:0] ACCESS_PRIVRO_USERRO = 3'h5;

   // execute setting
   localparam logic EXECUTE_ALLOWED = 1'b0;
   localparam logic EXECUTE_FORBIDDEN = 1'b1;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic [4:0] size_code;           // size is 2^(code+5) bytes
      logic exec_off;                  // execute_forbidden when set
      logic [2:0] access;              // one of the ACCESS_ codes
      logic [7:0] subregion_off_mask;  // bit n disables sub-region n
      logic region_on;                 // region takes part in checking
   } region_attributes_s;

   typedef struct packed {
      logic [ADDR_W-1:0] region_base;
      region_attributes_s region_attributes;
   } region_entry_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;  // access address
      logic priv;               // privileged access
      logic write;              // write access
      logic fetch;              // instruction fetch
      logic in_handler;         // hard fault or nmi handler running
   } access_req_s;

   localparam region_entry_s ENTRY_RESET = '0;

   // ************************************************************
   // decode functions
   // ************************************************************
   // address falls in the region, disabled sub-regions excluded
   function automatic logic region_match(input logic [ADDR_W-1:0] addr,
                                         input region_entry_s e);
      logic [5:0] k;
      logic [32:0] low_mask;
      logic [31:0] diff;
      logic [31:0] sub_sh;
      logic [2:0] sub_idx;
      k = 6'(e.region_attributes.size_code) + SIZE_LOG2_MIN;
      low_mask = (33'h0_0000_0001 << k) - 33'h0_0000_0001;
      diff = (addr ^ e.region_base) & ~low_mask[31:0];
      sub_sh = addr >> (k - SUB_SHIFT);
      sub_idx = sub_sh[2:0];
      region_match = (e.region_attributes.size_code <= SIZE_CODE_MAX) && (diff == '0);
      if (e.region_attributes.size_code >= SUB_MIN_CODE) begin
         region_match = region_match && !e.region_attributes.subregion_off_mask[sub_idx];
      end
   endfunction : region_match

   // read right for the given privilege
   function automatic logic may_read(input logic [2:0] acc, input logic priv);
      may_read = priv ? (acc inside {ACCESS_PRIVRW_USERNONE, ACCESS_PRIVRW_USERRO,
                                     ACCESS_PRIVRW_USERRW, ACCESS_PRIVRO_USERNONE,
                                     ACCESS_PRIVRO_USERRO})
                      : (acc inside {ACCESS_PRIVRW_USERRO, ACCESS_PRIVRW_USERRW,
                                     ACCESS_PRIVRO_USERRO});
   endfunction : may_read

   // write right for the given privilege
   function automatic logic may_write(input logic [2:0] acc, input logic priv);
      may_write = priv ? (acc inside {ACCESS_PRIVRW_USERNONE, ACCESS_PRIVRW_USERRO,
                                      ACCESS_PRIVRW_USERRW})
                       : (acc == ACCESS_PRIVRW_USERRW);
   endfunction : may_write

endpackage : rpu_pkg

// ---- tb/core_model.sv ----
// core_model: processor core side that programs regions and issues accesses
module core_model
   import rpu_pkg::*;
(
   input wire logic ref_clk_i,
   output logic unit_on_o,
   output logic bg_map_o,
   output logic chk_hnd_o,
   output logic cfg_wr_o,
   output logic cfg_rd_o,
   output logic [RGN_IDX_W-1:0] region_number_o,
   output logic [ADDR_W-1:0] region_base_o,
   output region_attributes_s region_attributes_o,
   input wire region_entry_s cfg_rd_data_i,
   input wire logic cfg_rd_valid_i,
   output logic acc_valid_o,
   output access_req_s acc_req_o,
   input wire logic acc_done_i,
   input wire logic acc_fault_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // ************************************************************
   // idle levels
   // ************************************************************
   initial begin
      {unit_on_o, bg_map_o, chk_hnd_o, cfg_wr_o, cfg_rd_o, acc_valid_o} = '0;
      region_number_o = '0;
      region_base_o = '0;
      region_attributes_o = '0;
      acc_req_o = '0;
   end

   // unit mode bits change just after an edge
   task automatic set_mode(input logic on, input logic bg, input logic hnd);
      @(posedge ref_clk_i);
      #1;
      unit_on_o = on;
      bg_map_o = bg;
      chk_hnd_o = hnd;
   endtask : set_mode

   // one strobe: base and attributes travel together
   task automatic cfg_put(input logic [2:0] n, input logic [31:0] b, input region_attributes_s a);
      @(posedge ref_clk_i);
      #1;
      cfg_wr_o = 1'b1;
      region_number_o = n;
      region_base_o = b;
      region_attributes_o = a;
      @(posedge ref_clk_i);
      #1;
      cfg_wr_o = 1'b0;
      // released bus shows the inverted values, not stale data
      region_number_o = ~n;
      region_base_o = ~b;
      region_attributes_o = ~a;
   endtask : cfg_put

   // callers pass a base aligned to the region size
   task automatic region_set(input logic [2:0] n, input logic [31:0] b, input region_attributes_s a);
      region_attributes_s off;
      off = a;
      off.region_on = 1'b0;
      cfg_put(n, b, off);
      cfg_put(n, b, a);
   endtask : region_set

   // read back one entry; data is taken the cycle after the strobe
   task automatic region_get(input logic [2:0] n, output region_entry_s e, output logic v);
      @(posedge ref_clk_i);
      #1;
      cfg_rd_o = 1'b1;
      region_number_o = n;
      @(posedge ref_clk_i);
      #1;
      cfg_rd_o = 1'b0;
      region_number_o = ~n;
      e = cfg_rd_data_i;
      v = cfg_rd_valid_i;
   endtask : region_get

   // one access; the answer stands for one cycle only
   task automatic access(input access_req_s r, output logic d, output logic f);
      @(posedge ref_clk_i);
      #1;
      acc_valid_o = 1'b1;
      acc_req_o = r;
      @(posedge ref_clk_i);
      #1;
      acc_valid_o = 1'b0;
      acc_req_o = ~r;
      d = acc_done_i;
      f = acc_fault_i;
   endtask : access
endmodule : core_model

// ---- tb/region_protection_unit_bench.sv ----
// region_protection_unit_bench: directed tests of the region protection unit
module region_protection_unit_bench
   import rpu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic on, bg, hnd, wr, rd, av, dn, ft, rv;
   logic [2:0] num;
   logic [31:0] base;
   region_attributes_s attr;
   region_entry_s rdat;
   access_req_s req;
   int error_cnt = 0;
   int check_count = 0;
   // per-code rights, bit n for access code n
   localparam logic [5:0] RD_P = 6'h3e, RD_U = 6'h2c, WR_P = 6'h0e, WR_U = 6'h08;

   always #4 ref_clk_i = ~ref_clk_i;

   region_protection_unit u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .unit_on_i(on), .privileged_background_map_i(bg), .check_in_fault_handlers_i(hnd),
      .cfg_wr_i(wr), .cfg_rd_i(rd), .region_number_i(num), .region_base_i(base),
      .region_attributes_i(attr), .cfg_rd_data_o(rdat), .cfg_rd_valid_o(rv),
      .acc_valid_i(av), .acc_req_i(req), .acc_done_o(dn), .acc_fault_o(ft));

   core_model u_core (.ref_clk_i(ref_clk_i), .unit_on_o(on), .bg_map_o(bg), .chk_hnd_o(hnd),
      .cfg_wr_o(wr), .cfg_rd_o(rd), .region_number_o(num), .region_base_o(base),
      .region_attributes_o(attr), .cfg_rd_data_i(rdat), .cfg_rd_valid_i(rv),
      .acc_valid_o(av), .acc_req_o(req), .acc_done_i(dn), .acc_fault_i(ft));

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   function automatic region_attributes_s at(input int sz, input logic x, input logic [2:0] ac,
                                             input logic [7:0] m, input logic en);
      at = '{size_code: 5'(sz), exec_off: x, access: ac, subregion_off_mask: m, region_on: en};
   endfunction : at

   // access and compare done pulse and fault flag
   task automatic acc_chk(input logic [31:0] a, input logic p, input logic w, input logic fe,
                          input logic h, input logic exp);
      logic d, f;
      u_core.access('{addr: a, priv: p, write: w, fetch: fe, in_handler: h}, d, f);
      check("acc_done", 64'(d), 64'h1);
      check("acc_fault", 64'(f), 64'(exp));
   endtask : acc_chk

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #(8 * 20000);
      error_cnt++;
      complete_run();
   end

   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      region_entry_s e;
      logic v;
      logic [32:0] lim;
      repeat (5) @(posedge ref_clk_i);
      #1;
      reset_n_i = 1'b1;
      u_core.region_get(3'h0, e, v);
      check("reset entry", 64'(e), 64'h0);
      check("rd valid", 64'(v), 64'h1);
      $display("test reset done");
      u_core.set_mode(1'b1, 1'b0, 1'b0);
      // every size code; codes up to 27 hit at the top byte, codes below 27 miss just above
      for (int c = 0; c < 32; c++) begin
         u_core.region_set(3'h3, 32'h0, at(c, 1'b0, ACCESS_PRIVRW_USERRW, 8'h00, 1'b1));
         lim = 33'h1 << (c + 5);
         acc_chk(32'(lim - 33'h1), 1'b0, 1'b0, 1'b0, 1'b0, c > 27);
         if (c < 27) acc_chk(lim[31:0], 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      end
      u_core.region_set(3'h3, 32'h0, at(0, 1'b0, ACCESS_NONE_NONE, 8'h00, 1'b0));
      $display("test sizes done");
      // every access code, both privileges, read and write
      for (int ac = 0; ac < 6; ac++) begin
         u_core.region_set(3'h1, 32'h2000, at(3, 1'b0, 3'(ac), 8'h00, 1'b1));
         acc_chk(32'h2010, 1'b1, 1'b0, 1'b0, 1'b0, !RD_P[ac]);
         acc_chk(32'h2010, 1'b0, 1'b0, 1'b0, 1'b0, !RD_U[ac]);
         acc_chk(32'h2010, 1'b1, 1'b1, 1'b0, 1'b0, !WR_P[ac]);
         acc_chk(32'h2010, 1'b0, 1'b1, 1'b0, 1'b0, !WR_U[ac]);
      end
      $display("test access codes done");
      // execute setting
      acc_chk(32'h2010, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      u_core.region_set(3'h1, 32'h2000, at(3, EXECUTE_FORBIDDEN, ACCESS_PRIVRO_USERRO, 8'h00, 1'b1));
      acc_chk(32'h2010, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      $display("test execute done");
      // sub-regions: mask a5 on 256 bytes, ignored on 128 bytes
      u_core.region_set(3'h1, 32'h2000, at(3, 1'b0, ACCESS_PRIVRW_USERRW, 8'ha5, 1'b1));
      for (int s = 0; s < 8; s++) begin
         acc_chk(32'h2000 + 32'(s * 32), 1'b0, 1'b1, 1'b0, 1'b0, 1'(8'ha5 >> s));
      end
      u_core.region_set(3'h1, 32'h2000, at(2, 1'b0, ACCESS_PRIVRW_USERRW, 8'hff, 1'b1));
      acc_chk(32'h2070, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      $display("test sub-regions done");
      // overlaps: higher number wins, disabled region kept but idle
      u_core.region_set(3'h1, 32'h2000, at(3, 1'b0, ACCESS_PRIVRW_USERRW, 8'h00, 1'b1));
      u_core.region_set(3'h0, 32'h2000, at(3, 1'b0, ACCESS_NONE_NONE, 8'h00, 1'b1));
      acc_chk(32'h2000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      u_core.region_set(3'h5, 32'h2000, at(0, 1'b0, ACCESS_NONE_NONE, 8'h00, 1'b1));
      acc_chk(32'h2000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      acc_chk(32'h2020, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      u_core.cfg_put(3'h5, 32'h2000, at(0, 1'b0, ACCESS_NONE_NONE, 8'h00, 1'b0));
      acc_chk(32'h2000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      u_core.region_get(3'h5, e, v);
      check("entry 5", 64'(e), 64'({32'h2000, at(0, 1'b0, ACCESS_NONE_NONE, 8'h00, 1'b0)}));
      $display("test overlap done");
      // unit off, background map, fault handlers
      acc_chk(32'h9000_0000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      u_core.set_mode(1'b1, 1'b1, 1'b0);
      acc_chk(32'h9000_0000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      acc_chk(32'h9000_0000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      acc_chk(32'h9000_0000, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      u_core.set_mode(1'b1, 1'b1, 1'b1);
      acc_chk(32'h9000_0000, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
      u_core.set_mode(1'b0, 1'b0, 1'b1);
      acc_chk(32'h9000_0000, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      acc_chk(32'h2000, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      $display("test unit modes done");
      complete_run();
   end
endmodule : region_protection_unit_bench
